// ===== design/refclk_defines.svh
// constants for the reference clock control block: control word layout,
// power-up field values, register offsets and clock figures.
// assumes inclusion by bare name from design and verification files.
`ifndef REFCLK_DEFINES_SVH
`define REFCLK_DEFINES_SVH

// address nibble of a serial control word and the code of this word
`define RC_ADDR_MSB     3
`define RC_ADDR_LSB     0
`define RC_ADDR_REF     4'h1

// field positions inside the reference control word
`define RC_OSC_EN_BIT   12
`define RC_BIAS_MSB     14
`define RC_BIAS_LSB     13
`define RC_DIV_MSB      10
`define RC_DIV_LSB      7

// power-up field values
`define RC_OSC_EN_RST   1'b1
`define RC_BIAS_RST     2'h0
`define RC_DIV_RST      4'h4

// plain register port offsets
`define RC_OFS_CTRL     8'h00
`define RC_OFS_STATUS   8'h04

// status word fields
`define RC_ST_OSC_BIT   0
`define RC_ST_DIV_BIT   1
`define RC_ST_ACC_LSB   8
`define RC_ST_FOR_LSB   16

`define RC_CLK_PERIOD_NS 10

`endif

// ===== design/refclk_pkg.sv
// types shared by the reference clock control block.
// assumes nothing of its surroundings.
package refclk_pkg;

	// decoded reference control fields
	typedef struct packed {
		logic       osc_en;
		logic [1:0] bias;
		logic [3:0] div;
	} ref_ctrl_s;

	// one cycle of the plain register port
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	// serial control pins driven by the host, asynchronous to clk_i
	typedef struct packed {
		logic sclk;
		logic sdata;
		logic sle;
	} serial_pins_s;

endpackage : refclk_pkg

// ===== design/serial_word_shifter.sv
// 32-bit serial control word shifter with pin synchronisers.
// assumes sclk, sdata and sle come from the host, unrelated to clk_i,
// and that sclk is much slower than clk_i.
`timescale 1ns/1ps
`default_nettype none

module serial_word_shifter (
	input  wire logic                     clk_i,
	input  wire logic                     arst_n_i,
	input  wire refclk_pkg::serial_pins_s pins_i,
	output var  logic [31:0]              word_o,
	output var  logic                     valid_o
);
	import refclk_pkg::*;

	serial_pins_s sync1_q;
	serial_pins_s sync2_q;
	logic         sclk_prev_q;
	logic         sle_prev_q;
	logic [31:0]  shift_q;
	logic         sclk_rise;
	logic         sle_rise;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pins_i;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_prev_q <= 1'b0;
			sle_prev_q  <= 1'b0;
		end else begin
			sclk_prev_q <= sync2_q.sclk;
			sle_prev_q  <= sync2_q.sle;
		end
	end

	assign sclk_rise = sync2_q.sclk & ~sclk_prev_q;
	assign sle_rise  = sync2_q.sle & ~sle_prev_q;

	// [RULE10] shift on sclk rise
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_q <= 32'h0000_0000;
		end else if (sclk_rise) begin
			shift_q <= {shift_q[30:0], sync2_q.sdata};
		end
	end

	// latch the whole word on the rising latch enable
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			word_o  <= 32'h0000_0000;
			valid_o <= 1'b0;
		end else begin
			valid_o <= sle_rise;
			if (sle_rise) begin
				word_o <= shift_q;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	shift_step_a: assert property ( // [RULE10]
		sclk_rise |=> shift_q == {$past(shift_q[30:0]), $past(sync2_q.sdata)})
		else $error("serial shift lost or misordered a bit");

	word_latch_a: assert property (
		sle_rise |=> valid_o && word_o == $past(shift_q))
		else $error("latched word differs from shift contents");

	latch_seen_c: cover property (sle_rise ##1 valid_o);

endmodule : serial_word_shifter

`default_nettype wire

// ===== design/divided_reference_output_divider.sv
// even divider for the divided reference output.
// assumes clk_i is the reference and div_i comes from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none

module divided_reference_output_divider #(
	parameter int unsigned DIV_W = 4
) (
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	input  wire logic [DIV_W-1:0] div_i,
	output var  logic             clk_div_o,
	output var  logic             active_o
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] div_q;
	logic             restart;

	assign restart = (div_i != div_q);

	// [RULE5] [RULE11] half period of div_i
	// [RULE7] each phase is div_i cycles
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q     <= '0;
			div_q     <= '0;
			clk_div_o <= 1'b0;
		end else begin
			div_q <= div_i;
			if (restart) begin
				cnt_q     <= '0;
				clk_div_o <= (div_i != '0);
			end else if (div_i == '0) begin
				// [RULE8] zero stops output
				cnt_q     <= '0;
				clk_div_o <= 1'b0;
			end else if (cnt_q == div_i - 1'b1) begin
				// either phase starts here, on a reference rising edge
				cnt_q     <= '0;
				clk_div_o <= ~clk_div_o;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			active_o <= 1'b0;
		end else begin
			active_o <= (div_i != '0);
		end
	end

	// helper: length of each output phase, checked on the next change
	logic             seen_q;
	logic [DIV_W:0]   len_q;
	logic [DIV_W:0]   prev_len_q;
	logic [1:0]       settled_q;
	logic             edge_seen;

	assign edge_seen = (clk_div_o != seen_q);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			seen_q     <= 1'b0;
			len_q      <= '0;
			prev_len_q <= '0;
			settled_q  <= 2'h0;
		end else begin
			seen_q <= clk_div_o;
			if (edge_seen) begin
				len_q      <= {{DIV_W{1'b0}}, 1'b1};
				prev_len_q <= len_q;
			end else if (len_q != '1) begin
				len_q <= len_q + 1'b1;
			end
			if (restart) begin
				settled_q <= 2'h0;
			end else if (edge_seen && settled_q != 2'h3) begin
				settled_q <= settled_q + 2'h1;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	half_period_a: assert property ( // [RULE11]
		edge_seen && settled_q != 2'h0 && !restart
		|-> len_q == {1'b0, div_i})
		else $error("output phase is not div cycles long");

	duty_equal_a: assert property ( // [RULE7]
		edge_seen && settled_q == 2'h3 && !restart
		|-> len_q == prev_len_q)
		else $error("high and low times differ");

	keeps_toggling_a: assert property ( // [RULE5]
		div_i != '0 && !restart
		|-> ##[1:16] (clk_div_o != $past(clk_div_o) || restart))
		else $error("divided output stalled with a nonzero divider");

	stop_zero_a: assert property ( // [RULE8]
		div_i == '0 && $past(div_i) == '0 |-> !clk_div_o)
		else $error("divided output toggles with divider zero");

	div_zero_c: cover property (div_i == '0 [*4]);
	div_max_c: cover property (div_i == '1 ##1 edge_seen);

endmodule : divided_reference_output_divider

`default_nettype wire

// ===== design/reference_osc_divided_reference_output_divider.sv
// reference oscillator control and divided reference output.
// assumes clk_i is the reference clock itself, arst_n_i is the chip enable
// pin, the serial pins come from the host and the register port is on clk_i.
//
// Notes on behaviour
// [RULE1] oscillator runs only while enable bit set
// [RULE2] enable defaults on; chip enable low stops it
// [RULE3] host clears bit for logic-level external reference
// [RULE4] two-bit crystal bias selects start-up current
// [RULE5] output divides by even ratio 2 to 30
// [RULE6] divider field powers up at divide-by-eight
// [RULE7] output equal high/low, inverted to reference; code changes the output on reference rising edges, not inverted
// [RULE8] divider field zero stops the output
// [RULE9] chip enable low restores every default
// [RULE10] words shift serially, sampled on serial clock rise
// [RULE11] ratio is twice the divider field value
`timescale 1ns/1ps
`default_nettype none

`include "refclk_defines.svh"

module reference_osc_divided_reference_output_divider #(
	parameter int unsigned DIV_W = 4,
	parameter int unsigned CNT_W = 8
) (
	input  wire logic                     clk_i,
	input  wire logic                     arst_n_i,
	input  wire refclk_pkg::bus_req_s     bus_i,
	output var  logic [31:0]              rdata_o,
	input  wire refclk_pkg::serial_pins_s ser_i,
	output var  logic                     osc_run_o,
	output var  logic [1:0]               crystal_bias_select_o,
	output var  logic                     divided_reference_output_o
);
	import refclk_pkg::*;

	// decode a control word into its fields
	function automatic ref_ctrl_s decode_ctrl(input logic [31:0] w);
		ref_ctrl_s c;
		c.osc_en = w[`RC_OSC_EN_BIT];
		c.bias   = w[`RC_BIAS_MSB:`RC_BIAS_LSB];
		c.div    = w[`RC_DIV_MSB:`RC_DIV_LSB];
		return c;
	endfunction : decode_ctrl

	// build the readback image of the stored fields
	function automatic logic [31:0] encode_ctrl(input ref_ctrl_s c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`RC_ADDR_MSB:`RC_ADDR_LSB] = `RC_ADDR_REF;
		w[`RC_OSC_EN_BIT] = c.osc_en;
		w[`RC_BIAS_MSB:`RC_BIAS_LSB] = c.bias;
		w[`RC_DIV_MSB:`RC_DIV_LSB] = c.div;
		return w;
	endfunction : encode_ctrl

	// a serial word belongs to this block when its address nibble matches
	function automatic logic is_ref_word(input logic [31:0] w);
		return w[`RC_ADDR_MSB:`RC_ADDR_LSB] == `RC_ADDR_REF;
	endfunction : is_ref_word

	localparam ref_ctrl_s CTRL_RST = '{
		osc_en: `RC_OSC_EN_RST,
		bias:   `RC_BIAS_RST,
		div:    `RC_DIV_RST
	};

	ref_ctrl_s        ctrl_q;
	logic [31:0]      ser_word;
	logic             ser_valid;
	logic             ser_load;
	logic             ser_foreign;
	logic             wr_ctrl;
	logic             rd_hit_ctrl;
	logic             rd_hit_status;
	logic             div_active;
	logic [CNT_W-1:0] acc_cnt_q;
	logic [CNT_W-1:0] for_cnt_q;
	logic [31:0]      status_w;

	// [RULE10] serial word capture
	serial_word_shifter u_shifter (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.pins_i   (ser_i),
		.word_o   (ser_word),
		.valid_o  (ser_valid)
	);

	assign ser_load    = ser_valid & is_ref_word(ser_word);
	assign ser_foreign = ser_valid & ~is_ref_word(ser_word);
	assign wr_ctrl     = bus_i.wr & (bus_i.addr == `RC_OFS_CTRL);
	assign rd_hit_ctrl   = bus_i.rd & (bus_i.addr == `RC_OFS_CTRL);
	assign rd_hit_status = bus_i.rd & (bus_i.addr == `RC_OFS_STATUS);

	// [RULE9] chip enable low restores defaults
	// [RULE6] divider starts at divide-by-eight
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_ctrl) begin
			// register port wins over a serial word in the same cycle
			ctrl_q <= decode_ctrl(bus_i.wdata);
		end else if (ser_load) begin
			ctrl_q <= decode_ctrl(ser_word);
		end
	end

	// [RULE1] oscillator follows its enable bit
	// [RULE2] forced off while chip enable low
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			osc_run_o <= 1'b0;
		end else begin
			osc_run_o <= ctrl_q.osc_en;
		end
	end

	// [RULE4] bias code to oscillator
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			crystal_bias_select_o <= `RC_BIAS_RST;
		end else begin
			crystal_bias_select_o <= ctrl_q.bias;
		end
	end

	// [RULE5] [RULE7] [RULE8] [RULE11] even divider
	divided_reference_output_divider #(
		.DIV_W (DIV_W)
	) u_divider (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.div_i     (ctrl_q.div),
		.clk_div_o (divided_reference_output_o),
		.active_o  (div_active)
	);

	// counts of accepted and foreign serial words, saturating
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			acc_cnt_q <= '0;
			for_cnt_q <= '0;
		end else begin
			if (ser_load && acc_cnt_q != '1) begin
				acc_cnt_q <= acc_cnt_q + 1'b1;
			end
			if (ser_foreign && for_cnt_q != '1) begin
				for_cnt_q <= for_cnt_q + 1'b1;
			end
		end
	end

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`RC_ST_OSC_BIT] = osc_run_o;
		status_w[`RC_ST_DIV_BIT] = div_active;
		status_w[`RC_ST_ACC_LSB +: CNT_W] = acc_cnt_q;
		status_w[`RC_ST_FOR_LSB +: CNT_W] = for_cnt_q;
	end

	// read data stand for one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_hit_ctrl) begin
			rdata_o <= encode_ctrl(ctrl_q);
		end else if (rd_hit_status) begin
			rdata_o <= status_w;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	osc_follow_a: assert property ( // [RULE1]
		(ser_load && !wr_ctrl) ##1 !(wr_ctrl || ser_load)
		|-> ##1 osc_run_o == $past(ser_word[`RC_OSC_EN_BIT], 2))
		else $error("oscillator run does not follow serial enable bit");

	ce_osc_off_a: assert property ( // [RULE2]
		@(posedge clk_i) disable iff (1'b0)
		!arst_n_i |-> !osc_run_o && ctrl_q.osc_en)
		else $error("oscillator not off or enable not default in reset");

	rst_div_a: assert property ( // [RULE6]
		@(posedge clk_i) disable iff (1'b0)
		!arst_n_i |-> ctrl_q.div == `RC_DIV_RST)
		else $error("divider field not at divide-by-eight in reset");

	rst_clear_a: assert property ( // [RULE9]
		@(posedge clk_i) disable iff (1'b0)
		!arst_n_i |-> ctrl_q == CTRL_RST && acc_cnt_q == '0
			&& rdata_o == 32'h0000_0000)
		else $error("settings not cleared while chip enable low");

	bias_follow_a: assert property ( // [RULE4]
		wr_ctrl ##1 !(wr_ctrl || ser_load)
		|-> ##1 crystal_bias_select_o
			== $past(bus_i.wdata[`RC_BIAS_MSB:`RC_BIAS_LSB], 2))
		else $error("bias output does not follow written field");

	ctrl_cause_a: assert property ( // [RULE10]
		$changed(ctrl_q) |-> $past(wr_ctrl || ser_load))
		else $error("control fields changed without a write");

	foreign_ignore_a: assert property ( // [RULE10]
		ser_foreign && !wr_ctrl |=> $stable(ctrl_q))
		else $error("word for another register altered control fields");

	read_back_a: assert property (
		rd_hit_ctrl |=> rdata_o == encode_ctrl($past(ctrl_q)))
		else $error("control readback mismatch");

	read_once_a: assert property (
		!bus_i.rd |=> rdata_o == 32'h0000_0000)
		else $error("read data present without a read strobe");

	serial_load_c: cover property (ser_load ##2 osc_run_o != $past(osc_run_o));
	osc_off_c: cover property ($fell(osc_run_o));
	div_stop_c: cover property (wr_ctrl && bus_i.wdata[`RC_DIV_MSB:`RC_DIV_LSB] == 4'h0);
	foreign_c: cover property (ser_foreign);

endmodule : reference_osc_divided_reference_output_divider

`default_nettype wire

// ===== verification/ref_osc_model.sv
// reference source at the oscillator pins: crystal or external oscillator.
// assumes run_i and bias_i come from the block, on the reference clock.
`timescale 1ns/1ps
`default_nettype none

module ref_osc_model #(
	parameter bit          EXT_CMOS   = 1'b0,
	parameter int unsigned START_BASE = 16
) (
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [1:0] bias_i,
	output var  logic       stable_o,
	output var  logic       clash_o
);
	int unsigned cnt_q = 0;

	always @(posedge clk_i) begin
		if (!run_i) begin
			cnt_q <= 0;
		end else if (cnt_q < START_BASE) begin
			cnt_q <= cnt_q + 1 + bias_i;
		end
	end

	assign stable_o = run_i && (cnt_q >= START_BASE);

	// cmos source on pin b fights a running amplifier
	assign clash_o = EXT_CMOS && run_i;
endmodule : ref_osc_model
`default_nettype wire

// ===== verification/test_reference_osc_divided_reference_output_divider.sv
// self-checking bench for the reference clock control block.
// assumes the design files and the reference source model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`include "refclk_defines.svh"

module test_reference_osc_divided_reference_output_divider;
	import refclk_pkg::*;

	logic         clk_i    = 1'b0;
	logic         arst_n_i = 1'b1;
	bus_req_s     bus      = '0;
	serial_pins_s ser      = '0;
	logic [31:0]  rdata_o;
	logic         osc_run_o;
	logic [1:0]   crystal_bias_select_o;
	logic         divided_reference_output_o;
	logic         stable;
	logic         clash;
	logic [31:0]  rd;
	int           error_cnt       = 0;
	int           samples_checked = 0;

	always #(`RC_CLK_PERIOD_NS / 2.0) clk_i = ~clk_i;

	reference_osc_divided_reference_output_divider dut (
		.clk_i                      (clk_i),
		.arst_n_i                   (arst_n_i),
		.bus_i                      (bus),
		.rdata_o                    (rdata_o),
		.ser_i                      (ser),
		.osc_run_o                  (osc_run_o),
		.crystal_bias_select_o      (crystal_bias_select_o),
		.divided_reference_output_o (divided_reference_output_o)
	);

	ref_osc_model #(.EXT_CMOS(1'b1), .START_BASE(16)) osc_src (
		.clk_i    (clk_i),
		.run_i    (osc_run_o),
		.bias_i   (crystal_bias_select_o),
		.stable_o (stable),
		.clash_o  (clash)
	);

	function automatic logic [31:0] cw(logic o, logic [1:0] b, logic [3:0] d);
		return {17'h0, b, o, 1'b0, d, 3'h0, 4'h1};
	endfunction : cw

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : settle

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge clk_i);
		bus.wr    <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clk_i);
		bus.rd   <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rdr

	// host word: msb first, sclk high 4 cycles and low 8 cycles, then latch
	task automatic ser_send(input logic [31:0] w);
		@(posedge clk_i);
		for (int i = 31; i >= 0; i--) begin
			ser.sdata <= w[i];
			repeat (4) @(posedge clk_i);
			ser.sclk <= 1'b1;
			repeat (4) @(posedge clk_i);
			ser.sclk <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
		ser.sle <= 1'b1;
		repeat (4) @(posedge clk_i);
		ser.sle   <= 1'b0;
		ser.sdata <= ~w[0];
		settle(12);
	endtask : ser_send

	// high and low phase lengths of the divided output
	task automatic measure(input int n);
		int hi;
		int lo;
		int w;
		hi = 0;
		lo = 0;
		w = 0;
		settle(2);
		while (divided_reference_output_o !== 1'b0 && w < 80) begin
			settle(1);
			w++;
		end
		while (divided_reference_output_o !== 1'b1 && w < 160) begin
			settle(1);
			w++;
		end
		while (divided_reference_output_o === 1'b1 && hi < 80) begin
			settle(1);
			hi++;
		end
		while (divided_reference_output_o === 1'b0 && lo < 80) begin
			settle(1);
			lo++;
		end
		check("high_phase", hi, n);
		check("low_phase", lo, n);
	endtask : measure

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (40000) @(posedge clk_i);
		error_cnt++;
		$display("Error watchdog expected end seen hang");
		test_done();
	end

	initial begin
		// a real falling edge, so every flop is reset before the first clock
		arst_n_i <= 1'b0;
		#1;
		check("osc_in_reset", osc_run_o, 1'b0);
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		settle(2);
		check("osc_default", osc_run_o, 1'b1);
		rdr(`RC_OFS_CTRL, rd);
		check("ctrl_default", rd, cw(1'b1, 2'h0, 4'h4));
		settle(1);
		check("rdata_one_cycle", rdata_o, 32'h0000_0000);
		measure(4);
		$display("test defaults done");

		for (int n = 1; n < 16; n++) begin
			wr(`RC_OFS_CTRL, cw(1'b1, 2'h0, n[3:0]));
			measure(n);
		end
		wr(`RC_OFS_CTRL, cw(1'b1, 2'h0, 4'h0));
		settle(4);
		rd = 0;
		for (int i = 0; i < 40; i++) begin
			settle(1);
			rd += divided_reference_output_o;
		end
		check("stopped_output", rd, 32'h0000_0000);
		$display("test divider done");

		wr(`RC_OFS_CTRL, cw(1'b0, 2'h0, 4'h4));
		settle(1);
		check("osc_off", osc_run_o, 1'b0);
		check("no_clash", clash, 1'b0);
		for (int b = 0; b < 4; b++) begin
			wr(`RC_OFS_CTRL, cw(1'b1, b[1:0], 4'h4));
			settle(1);
			check("bias", crystal_bias_select_o, b[1:0]);
			check("osc_on", osc_run_o, 1'b1);
			settle(18);
			check("osc_started", stable, 1'b1);
		end
		$display("test oscillator done");

		ser_send(32'hA5A0_4181);
		check("ser_bias", crystal_bias_select_o, 2'h2);
		check("ser_osc", osc_run_o, 1'b0);
		rdr(`RC_OFS_CTRL, rd);
		check("ser_ctrl", rd, cw(1'b0, 2'h2, 4'h3));
		measure(3);
		ser_send(32'h0000_1A02);
		rdr(`RC_OFS_CTRL, rd);
		check("foreign_ignored", rd, cw(1'b0, 2'h2, 4'h3));
		rdr(`RC_OFS_STATUS, rd);
		check("status", rd, 32'h0001_0102);
		$display("test serial done");

		// read-only and unmapped places
		wr(`RC_OFS_STATUS, 32'hFFFF_FFFF);
		wr(8'h08, 32'hFFFF_FFFF);
		rdr(8'h08, rd);
		check("unmapped", rd, 32'h0000_0000);
		rdr(`RC_OFS_CTRL, rd);
		check("ctrl_kept", rd, cw(1'b0, 2'h2, 4'h3));
		$display("test access done");

		wr(`RC_OFS_CTRL, cw(1'b0, 2'h3, 4'h9));
		@(posedge clk_i);
		arst_n_i <= 1'b0;
		#1;
		check("reset_osc", osc_run_o, 1'b0);
		check("reset_out", divided_reference_output_o, 1'b0);
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		settle(2);
		rdr(`RC_OFS_CTRL, rd);
		check("ctrl_restored", rd, cw(1'b1, 2'h0, 4'h4));
		check("bias_restored", crystal_bias_select_o, 2'h0);
		rdr(`RC_OFS_STATUS, rd);
		check("status_restored", rd, 32'h0000_0003);
		measure(4);
		$display("test reset done");
		test_done();
	end
endmodule : test_reference_osc_divided_reference_output_divider
`default_nettype wire
